/* File: bench/cse_mem_model.sv */
// partner model of the external memory: keeps write beats and replays them as read beats
`timescale 1ns/1ps
module cse_mem_model (
    // clock
    input  wire logic        clk_i,
    // write beats from the block
    input  wire logic        wr_valid_i,
    input  wire logic [31:0] wr_data_i,
    output logic             wr_ready_o,
    // read replay
    input  wire logic        rd_go_i,
    output logic             rd_valid_o,
    output logic [31:0]      rd_data_o,
    output int               beats_o
);
    logic [31:0] store [$];
    initial begin
        wr_ready_o = 1'h0;
        rd_valid_o = 1'h0;
        rd_data_o  = 32'h0;
        beats_o    = 0;
    end
    // random stalls both ways; idle data toggles so a stale beat never looks good
    always @(posedge clk_i) begin
        if (wr_valid_i && wr_ready_o) begin
            store.push_back(wr_data_i);
        end
        wr_ready_o <= ($urandom_range(3, 0) != 0);
        if (rd_go_i && store.size() > 0 && $urandom_range(1, 0) == 1) begin
            rd_valid_o <= 1'h1;
            rd_data_o  <= store.pop_front();
        end else begin
            rd_valid_o <= 1'h0;
            rd_data_o  <= ~rd_data_o;
        end
        beats_o <= store.size();
    end
endmodule

/* File: bench/test_config_strap_and_edc.sv */
// self-checking bench for strap capture and the check-bit path
`timescale 1ns/1ps
module test_config_strap_and_edc;
    import cse_pkg::*;
    logic        clk_sys_i = 0, reset_n_i = 0, mrst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, done, edc, orgv, fast, rs, ws, ft, xs, sc, se, single;
    logic        wrdy, mwv, mwc, mwr, rdv, cv, cf, rgo = 0, wv = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, mwd, rdd, rd, ex, inj;
    logic [2:0]  cnum;
    logic [1:0]  org;
    logic [13:0] ae, af, o;
    logic [63:0] wd = 0, cd, dv;
    logic [13:0] ofs [4] = '{14'h007F, 14'h03FF, 14'h0FFF, 14'h3FFF};
    cse_straps_t st = '0, sv;
    int          num_errors = 0, total_checks = 0, nb, ncorr = 0, b;

    // one clock stands in for the user port clocks, well under every port limit
    always #12.5 clk_sys_i = ~clk_sys_i;

    cse_top u_cse_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
        .pslverr_o(pslverr), .master_reset_input_n_i(mrst_n), .memory_topology_select_i(st.topo),
        .memory_part_type_i(st.ptype), .memory_clock_rate_select_i(st.speed), .read_port_async_select_i(st.read_port_async_select),
        .write_port_async_select_i(st.write_port_async_select), .flag_offset_default_select_i(st.fsel),
        .fall_through_mode_pin_i(st.fall_through_mode_pin), .expansion_mode_select_i(st.expn), .boundary_scan_enable_i(st.scan),
        .config_done_o(done), .error_correction_en_o(edc), .config_number_o(cnum), .mem_org_o(org),
        .mem_org_valid_o(orgv), .mem_clk_fast_o(fast), .read_port_sync_o(rs), .write_port_sync_o(ws),
        .almost_empty_offset_o(ae), .almost_full_offset_o(af), .fall_through_o(ft), .expansion_standard_o(xs),
        .boundary_scan_on_o(sc), .wr_valid_i(wv), .wr_data_i(wd), .wr_ready_o(wrdy), .mem_wr_valid_o(mwv),
        .mem_wr_data_o(mwd), .mem_wr_check_o(mwc), .mem_wr_ready_i(mwr), .mem_rd_valid_i(rdv),
        .mem_rd_data_i(rdd), .cache_valid_o(cv), .cache_data_o(cd), .cache_fixed_o(cf));

    cse_mem_model u_cse_mem_model (.clk_i(clk_sys_i), .wr_valid_i(mwv), .wr_data_i(mwd), .wr_ready_o(mwr),
        .rd_go_i(rgo), .rd_valid_o(rdv), .rd_data_o(rdd), .beats_o(nb));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // bounded wait, sampled at each rising edge before that edge's updates
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (n > 300) begin
                num_errors++;
                end_of_test();
            end
        end while (s !== 1'b1);
    endtask

    // one apb transfer; an idle edge after it keeps drivers single per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'h1;
        wait_hi(pready);
        rd = prdata;
        se = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys_i);
    endtask

    // expected status word from the pins held at master reset
    function automatic logic [31:0] cfg_exp(input cse_straps_t s);
        logic       e;
        logic [2:0] n;
        e = s.topo inside {3'h2, 3'h3, 3'h5, 3'h6};
        case (s.topo)
            3'h0, 3'h2: n = 3'h1;
            3'h1, 3'h3: n = 3'h2;
            3'h5, 3'h7: n = 3'h3;
            default:    n = 3'h4;
        endcase
        if (s.ptype == 2'h3 && n != 3'h2) begin
            n = (n == 3'h4) ? 3'h6 : n + 3'h4;
        end
        return {14'h0000, n, 1'h1, s.scan, s.expn, s.fall_through_mode_pin, s.fsel, s.write_port_async_select, s.read_port_async_select, s.speed, s.ptype, s.topo, e};
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h8D04E309));
        repeat (4) @(posedge clk_sys_i);
        reset_n_i <= 1'h1;
        // every topology code in three passes: clean, one bad bit, two bad bits
        for (int i = 0; i < 24; i++) begin
            sv = 13'($urandom);
            sv.topo = i[2:0];
            ex = cfg_exp(sv);
            o = ofs[sv.fsel];
            mrst_n <= 1'h0;
            st <= sv;
            repeat (5) @(posedge clk_sys_i);
            mrst_n <= 1'h1;
            wait_hi(wrdy);
            st <= ~sv;
            repeat (4) @(posedge clk_sys_i);
            chk({edc, cnum}, {ex[0], ex[17:15]});
            chk({org, orgv, fast, rs, ws}, {sv.ptype, sv.ptype != 2'h1, sv.speed, sv.read_port_async_select, sv.write_port_async_select});
            chk({ae, af, ft, xs, sc, done}, {o, o, sv.fall_through_mode_pin, sv.expn, sv.scan, 1'h1});
            apb(1'h0, 8'h00, 32'h0);
            chk(rd, ex);
            apb(1'h0, 8'h04, 32'h0);
            chk(rd, 32'(o));
            b = $urandom_range(30, 0);
            inj = (i / 8 == 0) ? 32'h0 : (i / 8 == 1) ? 32'h1 << b : 32'h3 << b;
            single = ex[0] && (i / 8 == 1);
            ncorr += single;
            apb(1'h1, 8'h0C, inj);
            dv = {$urandom, $urandom};
            wd <= dv;
            wv <= 1'h1;
            wait_hi(wrdy);
            wv <= 1'h0;
            wait_hi(wrdy);
            chk(64'(nb), ex[0] ? 64'h3 : 64'h2);
            rgo <= 1'h1;
            wait_hi(cv);
            rgo <= 1'h0;
            chk({cf, cd}, {single, single ? dv : dv ^ {32'h0, inj}});
        end
        apb(1'h0, 8'h08, 32'h0);
        chk(rd, 32'(ncorr));
        apb(1'h1, 8'h08, 32'h0);
        apb(1'h0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        apb(1'h1, 8'h00, 32'hFFFFFFFF);
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, ex);
        apb(1'h0, 8'h10, 32'h0);
        chk({se, rd}, 33'h100000000);
        end_of_test();
    end
endmodule

/* File: rtl/cse_pkg.sv */
// constants and shared types for the strap decode and check-bit path
package cse_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CSE_REG_CFG  = 8'h00;
    localparam logic [7:0] CSE_REG_OFS  = 8'h04;
    localparam logic [7:0] CSE_REG_CORR = 8'h08;
    localparam logic [7:0] CSE_REG_INJ  = 8'h0C;

    // ------------------------------------------------------------
    // strap codes
    // ------------------------------------------------------------
    localparam logic [2:0] CSE_TOPO_15_OFF = 3'h0;
    localparam logic [2:0] CSE_TOPO_15_ON  = 3'h2;
    localparam logic [2:0] CSE_TOPO_2_OFF  = 3'h1;
    localparam logic [2:0] CSE_TOPO_2_ON   = 3'h3;
    localparam logic [2:0] CSE_TOPO_37_OFF = 3'h7;
    localparam logic [2:0] CSE_TOPO_37_ON  = 3'h5;
    localparam logic [2:0] CSE_TOPO_46_ON  = 3'h6;
    localparam logic [1:0] CSE_TYPE_4X32   = 2'h0;
    localparam logic [1:0] CSE_TYPE_UNUSED = 2'h1;
    localparam logic [1:0] CSE_TYPE_8X32   = 2'h2;
    localparam logic [1:0] CSE_TYPE_16X16  = 2'h3;

    // ------------------------------------------------------------
    // default flag offsets
    // ------------------------------------------------------------
    localparam logic [13:0] CSE_OFS_0 = 14'h007F;
    localparam logic [13:0] CSE_OFS_1 = 14'h03FF;
    localparam logic [13:0] CSE_OFS_2 = 14'h0FFF;
    localparam logic [13:0] CSE_OFS_3 = 14'h3FFF;

    // ------------------------------------------------------------
    // widths and types
    // ------------------------------------------------------------
    localparam int CSE_DATA_W = 64;
    localparam int CSE_HAM_W  = 7;

    // static pins in capture order
    typedef struct packed {
        logic       scan;
        logic       expn;
        logic       fall_through_mode_pin;
        logic [1:0] fsel;
        logic       write_port_async_select;
        logic       read_port_async_select;
        logic       speed;
        logic [1:0] ptype;
        logic [2:0] topo;
    } cse_straps_t;

    // memory write sequencer
    typedef enum logic [3:0] {
        CSE_W_IDLE = 4'h1,
        CSE_W_LO   = 4'h2,
        CSE_W_HI   = 4'h4,
        CSE_W_CHK  = 4'h8
    } cse_wst_t;
endpackage

/* File: rtl/cse_top.sv */
// strap capture at master reset, check-bit generation and single-bit correction
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps

// How it works
// [R1] with correction on, any single flipped data bit read back is repaired
// [R2] two bad bits, or any even count, pass unchanged and unreported
// [R3] eight check bits are formed for each 64-bit word and stored with it
// [R4] with correction on a write is low beat, high beat, then check beat
// [R5] read check bits are decoded against data; result goes to prefetch cache
// [R6] topology 000/010 and 111/101 select correction off/on
// [R7] topology 001 selects correction off, 011 on, for configuration 2
// [R8] codes 100/110 conflict; one code is a parameter, default 110 on
// [R9] part type 00 4Mx32, 10 8Mx32, 11 16Mx16, 01 unused
// [R10] memory clock rate select low means 133MHz, high 166MHz
// [R11] read port async select 0 gives async read port, 1 sync
// [R12] write port async select 0 gives async write port, 1 sync
// [R13] offset select 00,01,10,11 gives 127, 1023, 4095, 16383
// [R14] fall-through pin 0 standard timing, 1 first-word fall-through
// [R15] expansion select 0 for fall-through, 1 for standard depth expansion
// [R16] boundary scan enable 0 disables scan, 1 enables it
// [R17] with correction on, 24 bits of each check beat stay unused
// [R18] user keeps port clocks within per-configuration maximum
// [R19] user holds straps steady before master reset rises
// [R20] settings are sampled during master reset and frozen afterwards
// [R21] check code is Hamming style; syndrome names the bit to invert
module cse_top
    import cse_pkg::*;
#(
    parameter logic [2:0] EDC_ON_CODE_46 = cse_pkg::CSE_TOPO_46_ON
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    // static pins
    input  wire logic        master_reset_input_n_i,
    input  wire logic [2:0]  memory_topology_select_i,
    input  wire logic [1:0]  memory_part_type_i,
    input  wire logic        memory_clock_rate_select_i,
    input  wire logic        read_port_async_select_i,
    input  wire logic        write_port_async_select_i,
    input  wire logic [1:0]  flag_offset_default_select_i,
    input  wire logic        fall_through_mode_pin_i,
    input  wire logic        expansion_mode_select_i,
    input  wire logic        boundary_scan_enable_i,
    // decoded settings
    output logic             config_done_o,
    output logic             error_correction_en_o,
    output logic [2:0]       config_number_o,
    output logic [1:0]       mem_org_o,
    output logic             mem_org_valid_o,
    output logic             mem_clk_fast_o,
    output logic             read_port_sync_o,
    output logic             write_port_sync_o,
    output logic [13:0]      almost_empty_offset_o,
    output logic [13:0]      almost_full_offset_o,
    output logic             fall_through_o,
    output logic             expansion_standard_o,
    output logic             boundary_scan_on_o,
    // user write word
    input  wire logic        wr_valid_i,
    input  wire logic [63:0] wr_data_i,
    output logic             wr_ready_o,
    // memory write beats
    output logic             mem_wr_valid_o,
    output logic [31:0]      mem_wr_data_o,
    output logic             mem_wr_check_o,
    input  wire logic        mem_wr_ready_i,
    // memory read beats
    input  wire logic        mem_rd_valid_i,
    input  wire logic [31:0] mem_rd_data_i,
    // prefetch cache word
    output logic             cache_valid_o,
    output logic [63:0]      cache_data_o,
    output logic             cache_fixed_o
);
    import cse_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        mrs_m;
        logic        mrs_s;
        cse_straps_t pin_m;
        cse_straps_t pin_s;
        cse_straps_t cfg;
        logic        edc;
        logic [2:0]  num;
        logic        done;
        logic        org_ok;
        logic [13:0] ofs;
        cse_wst_t    wst;
        logic        wr_rdy;
        logic [63:0] wdat;
        logic [7:0]  wchk;
        logic        mw_valid;
        logic [31:0] mw_data;
        logic        mw_chk;
        logic [1:0]  rcnt;
        logic        rdone;
        logic [31:0] rlo;
        logic [31:0] rhi;
        logic [7:0]  rchk;
        logic        c_valid;
        logic [63:0] c_data;
        logic        c_fix;
        logic [15:0] corr;
        logic [31:0] inj;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } cse_state_t;

    localparam cse_state_t CSE_RST = '{wst: CSE_W_IDLE, default: '0};

    cse_state_t s;
    cse_state_t n;

    // ------------------------------------------------------------
    // check code helpers
    // ------------------------------------------------------------
    // codeword position of data bit idx: skips the power-of-two slots
    function automatic logic [6:0] cse_pos(input int idx);
        int         cnt;
        logic [6:0] p;
        cnt = 0;
        p = 7'h03;
        for (int k = 3; k < 128; k++) begin
            if ((k & (k - 1)) != 0) begin
                if (cnt == idx) begin
                    p = 7'(k);
                end
                cnt++;
            end
        end
        return p;
    endfunction

    // seven hamming bits plus overall parity in bit 7
    function automatic logic [7:0] cse_check(input logic [63:0] d);
        logic [7:0] c;
        logic [6:0] p;
        c = 8'h00;
        for (int i = 0; i < CSE_DATA_W; i++) begin
            p = cse_pos(i);
            for (int b = 0; b < CSE_HAM_W; b++) begin
                if (p[b]) begin
                    c[b] = c[b] ^ d[i]; // [R21]
                end
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction

    // default offset table
    function automatic logic [13:0] cse_ofs(input logic [1:0] sel);
        logic [13:0] o;
        unique case (sel)
            2'h0: o = CSE_OFS_0;
            2'h1: o = CSE_OFS_1;
            2'h2: o = CSE_OFS_2;
            2'h3: o = CSE_OFS_3;
        endcase
        return o;
    endfunction

    // ------------------------------------------------------------
    // read-side decode
    // ------------------------------------------------------------
    logic [7:0]  rgen;
    logic [6:0]  syn;
    logic        perr;
    logic        hit;
    logic [63:0] fixed;

    // odd error count plus a syndrome naming a data bit means one bad bit;
    // an even count is left alone so double errors are never miscorrected
    always_comb begin
        rgen = cse_check({s.rhi, s.rlo});
        syn = s.rchk[6:0] ^ rgen[6:0]; // [R5]
        perr = ^{s.rhi, s.rlo, s.rchk};
        hit = 1'b0;
        fixed = {s.rhi, s.rlo};
        for (int i = 0; i < CSE_DATA_W; i++) begin
            if (s.edc && perr && syn == cse_pos(i)) begin
                fixed[i] = ~fixed[i]; // [R1] [R21]
                hit = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic wr_acc;
    logic apb_wr;
    logic corr_inc;

    always_comb begin
        n = s;
        // pins come from outside: two flops before use
        n.mrs_m = master_reset_input_n_i;
        n.mrs_s = s.mrs_m;
        n.pin_m = '{scan: boundary_scan_enable_i, expn: expansion_mode_select_i,
                    fall_through_mode_pin: fall_through_mode_pin_i, fsel: flag_offset_default_select_i,
                    write_port_async_select: write_port_async_select_i, read_port_async_select: read_port_async_select_i,
                    speed: memory_clock_rate_select_i, ptype: memory_part_type_i,
                    topo: memory_topology_select_i};
        n.pin_s = s.pin_m;

        // capture while master reset is low, then hold
        n.done = s.mrs_s; // [R20]
        if (!s.mrs_s) begin
            n.cfg = s.pin_s; // [R19] [R20]
            n.ofs = cse_ofs(s.pin_s.fsel); // [R13]
            n.org_ok = s.pin_s.ptype != CSE_TYPE_UNUSED; // [R9]
            n.edc = (s.pin_s.topo == CSE_TOPO_15_ON) || // [R6]
                    (s.pin_s.topo == CSE_TOPO_2_ON) || // [R7]
                    (s.pin_s.topo == CSE_TOPO_37_ON) ||
                    (s.pin_s.topo == EDC_ON_CODE_46); // [R8]
            unique case (s.pin_s.topo)
                CSE_TOPO_15_OFF, CSE_TOPO_15_ON: begin
                    n.num = (s.pin_s.ptype == CSE_TYPE_16X16) ? 3'h5 : 3'h1;
                end
                CSE_TOPO_2_OFF, CSE_TOPO_2_ON: begin
                    n.num = 3'h2; // [R7]
                end
                CSE_TOPO_37_OFF, CSE_TOPO_37_ON: begin
                    n.num = (s.pin_s.ptype == CSE_TYPE_16X16) ? 3'h7 : 3'h3;
                end
                default: begin
                    n.num = (s.pin_s.ptype == CSE_TYPE_16X16) ? 3'h6 : 3'h4; // [R8]
                end
            endcase
        end

        // write sequencer: memory stall holds the current beat
        wr_acc = s.wr_rdy && wr_valid_i;
        unique case (s.wst)
            CSE_W_IDLE: begin
                if (wr_acc) begin
                    n.wdat = wr_data_i;
                    n.wchk = cse_check(wr_data_i); // [R3]
                    n.mw_valid = 1'b1;
                    n.mw_data = wr_data_i[31:0] ^ s.inj;
                    n.wst = CSE_W_LO;
                end
            end
            CSE_W_LO: begin
                if (mem_wr_ready_i) begin
                    n.mw_data = s.wdat[63:32];
                    n.wst = CSE_W_HI;
                end
            end
            CSE_W_HI: begin
                if (mem_wr_ready_i && s.edc) begin
                    n.mw_data = {24'h000000, s.wchk}; // [R4] [R17]
                    n.mw_chk = 1'b1;
                    n.wst = CSE_W_CHK;
                end else if (mem_wr_ready_i) begin
                    n.mw_valid = 1'b0;
                    n.wst = CSE_W_IDLE;
                end
            end
            CSE_W_CHK: begin
                if (mem_wr_ready_i) begin
                    n.mw_valid = 1'b0;
                    n.mw_chk = 1'b0;
                    n.wst = CSE_W_IDLE;
                end
            end
        endcase
        n.wr_rdy = (n.wst == CSE_W_IDLE) && s.mrs_s && !wr_acc;

        // read collection: two data beats, then check beat if enabled
        n.rdone = 1'b0;
        if (mem_rd_valid_i) begin
            unique case (s.rcnt)
                2'h0: begin
                    n.rlo = mem_rd_data_i;
                    n.rcnt = 2'h1;
                end
                2'h1: begin
                    n.rhi = mem_rd_data_i;
                    n.rchk = 8'h00;
                    n.rcnt = s.edc ? 2'h2 : 2'h0;
                    n.rdone = !s.edc;
                end
                default: begin
                    n.rchk = mem_rd_data_i[7:0]; // [R5]
                    n.rcnt = 2'h0;
                    n.rdone = 1'b1;
                end
            endcase
        end

        // publish to the prefetch cache one cycle after the last beat
        n.c_valid = s.rdone;
        n.c_fix = s.rdone && hit;
        if (s.rdone) begin
            n.c_data = fixed; // [R1] [R2] [R5]
        end

        // apb: answer in the access cycle after setup
        n.pready = psel_i && !penable_i && !s.pready;
        apb_wr = psel_i && penable_i && s.pready && pwrite_i;
        if (psel_i && !penable_i) begin
            n.pslverr = 1'b0;
            unique case (paddr_i)
                CSE_REG_CFG: begin
                    n.prdata = {14'h0000, s.num, s.done, s.cfg, s.edc};
                end
                CSE_REG_OFS: begin
                    n.prdata = {18'h00000, s.ofs};
                end
                CSE_REG_CORR: begin
                    n.prdata = {16'h0000, s.corr};
                end
                CSE_REG_INJ: begin
                    n.prdata = s.inj;
                end
                default: begin
                    n.prdata = 32'h00000000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_wr && paddr_i == CSE_REG_INJ) begin
            n.inj = pwdata_i;
        end

        // a correction in the clearing cycle still counts
        corr_inc = s.rdone && hit && (s.corr != 16'hFFFF);
        if (apb_wr && paddr_i == CSE_REG_CORR) begin
            n.corr = corr_inc ? 16'h0001 : 16'h0000;
        end else if (corr_inc) begin
            n.corr = s.corr + 16'h0001;
        end

        // master reset clears the data path but not software state
        if (!s.mrs_s) begin
            n.wst = CSE_W_IDLE;
            n.wr_rdy = 1'b0;
            n.mw_valid = 1'b0;
            n.mw_chk = 1'b0;
            n.rcnt = 2'h0;
            n.rdone = 1'b0;
            n.c_valid = 1'b0;
            n.c_data = 64'h0000000000000000;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            s <= CSE_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pready_o = s.pready;
    assign prdata_o = s.prdata;
    assign pslverr_o = s.pslverr;
    assign config_done_o = s.done;
    assign error_correction_en_o = s.edc;
    assign config_number_o = s.num;
    assign mem_org_o = s.cfg.ptype; // [R9]
    assign mem_org_valid_o = s.org_ok; // [R9]
    assign mem_clk_fast_o = s.cfg.speed; // [R10]
    assign read_port_sync_o = s.cfg.read_port_async_select; // [R11]
    assign write_port_sync_o = s.cfg.write_port_async_select; // [R12]
    assign almost_empty_offset_o = s.ofs; // [R13]
    assign almost_full_offset_o = s.ofs; // [R13]
    assign fall_through_o = s.cfg.fall_through_mode_pin; // [R14]
    assign expansion_standard_o = s.cfg.expn; // [R15]
    assign boundary_scan_on_o = s.cfg.scan; // [R16]
    assign wr_ready_o = s.wr_rdy;
    assign mem_wr_valid_o = s.mw_valid;
    assign mem_wr_data_o = s.mw_data;
    assign mem_wr_check_o = s.mw_chk;
    assign cache_valid_o = s.c_valid;
    assign cache_data_o = s.c_data;
    assign cache_fixed_o = s.c_fix;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [7:0] cache_chk;
    logic [7:0] held_chk;

    // recomputed codes only the checks read
    always_comb begin
        cache_chk = cse_check(cache_data_o);
        held_chk = cse_check(s.wdat);
    end

    default clocking cse_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    cfg_hold_a: assert property (s.done && $past(s.done) |-> $stable(s.cfg) && $stable(s.edc)) // [R20]
        else $error("settings changed after master reset");
    edc_on_a: assert property (s.done && (s.cfg.topo == CSE_TOPO_15_ON || s.cfg.topo == CSE_TOPO_37_ON) // [R6]
        |-> error_correction_en_o)
        else $error("correction not enabled for on code");
    edc_off_a: assert property (s.done && (s.cfg.topo == CSE_TOPO_15_OFF || s.cfg.topo == CSE_TOPO_37_OFF) // [R6]
        |-> !error_correction_en_o)
        else $error("correction enabled for off code");
    cfg_two_a: assert property (s.done && s.cfg.topo[2] == 1'b0 && s.cfg.topo[0] // [R7]
        |-> config_number_o == 3'h2 && error_correction_en_o == s.cfg.topo[1])
        else $error("configuration 2 decode wrong");
    chk_follow_a: assert property (mem_wr_valid_o && mem_wr_ready_i && s.wst == CSE_W_HI && s.edc // [R4]
        |=> mem_wr_valid_o && mem_wr_check_o)
        else $error("check beat missing after data beats");
    chk_order_a: assert property ($rose(mem_wr_check_o) |-> $past(s.wst) == CSE_W_HI && s.edc) // [R4]
        else $error("check beat out of order");
    chk_value_a: assert property (mem_wr_check_o |-> mem_wr_data_o == {24'h000000, held_chk}) // [R3] [R17]
        else $error("check beat content wrong");
    fix_single_a: assert property (cache_valid_o && cache_fixed_o |-> cache_chk[6:0] == $past(s.rchk[6:0])) // [R1]
        else $error("single error not repaired");
    multi_pass_a: assert property (cache_valid_o && $past(!perr) |-> cache_data_o == $past({s.rhi, s.rlo})) // [R2]
        else $error("even error count altered data");
    offset_a: assert property ($rose(s.done) |-> almost_empty_offset_o == cse_ofs($past(s.cfg.fsel))) // [R13]
        else $error("default offset wrong");
endmodule
